// ==== inc/flash_id_pkg.sv ====
// Constants and types for the identification and discovery-table readout
package flash_id_pkg;

	// Protocol selected by the device configuration
	typedef enum logic [1:0] {
		PROTO_EXTENDED = 2'b00,
		PROTO_DUAL     = 2'b01,
		PROTO_QUAD     = 2'b10
	} proto_t;

	// Link-side sequence states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CMD    = 3'b001,
		ST_ADDR   = 3'b010,
		ST_DUMMY  = 3'b011,
		ST_DATA   = 3'b100,
		ST_IGNORE = 3'b101
	} state_t;

	// What the byte source streams
	typedef enum logic [1:0] {
		SRC_ID_FULL  = 2'b00,
		SRC_ID_SHORT = 2'b01,
		SRC_TABLE    = 2'b10
	} source_t;

	localparam logic [4:0]  CMD_BITS        = 5'h08;
	localparam logic [4:0]  ADDR_BITS       = 5'h18;
	localparam logic [4:0]  DUMMY_EXT_DUAL  = 5'h08;
	localparam logic [4:0]  DUMMY_QUAD      = 5'h0a;
	localparam logic [3:0]  BYTE_BITS       = 4'h8;
	localparam int          TABLE_AW        = 11;       // 2048-byte table space
	localparam logic [10:0] ID_SHORT_LAST   = 11'h002;  // Manufacturer and two device bytes
	localparam logic [10:0] ID_FULL_LAST    = 11'h013;  // Plus 17-byte unique ID
	localparam logic [10:0] ID_UID_BASE     = 11'h003;
	localparam logic [10:0] ID_FACTORY_BASE = 11'h006;
	localparam logic [7:0]  UID_LENGTH      = 8'h10;

	// First extended ID byte fields
	localparam int         EXT_PROTECT_POS = 5;
	localparam int         EXT_EXEC_POS    = 4;
	localparam int         EXT_PIN_POS     = 3;
	localparam int         EXT_ADDR_POS    = 2;
	localparam logic       EXT_PROTECT_STD = 1'b0;
	localparam logic       EXT_ADDR_BYTE   = 1'b0;
	localparam logic [1:0] EXT_ARCH_UNIF   = 2'b00;

	// Table header, bytes 00h to 0Fh
	localparam logic [7:0] TABLE_HEADER [0:15] = '{
		8'h53, 8'h46, 8'h44, 8'h50,  // Signature
		8'h00, 8'h01,                // Minor, major revision
		8'h00, 8'hff,                // Header count, unused
		8'h00, 8'h00, 8'h01,         // Parameter ID, minor, major
		8'h09,                       // Length in double words
		8'h30, 8'h00, 8'h00,         // Table pointer
		8'hff                        // Unused
	};
	localparam logic [10:0] TABLE_PARAM_BASE = 11'h030;
	localparam logic [10:0] TABLE_PARAM_LAST = 11'h033;
	localparam logic [7:0]  TABLE_FILL       = 8'hff;

	// Byte 30h fields
	localparam logic [1:0] P30_ERASE_SIZE = 2'b01;
	localparam logic       P30_WR_GRAN    = 1'b1;
	localparam logic       P30_WE_REQ     = 1'b0;
	localparam logic       P30_WE_SEL     = 1'b0;
	localparam logic [2:0] P30_UNUSED     = 3'b111;
	// Byte 32h fields, then reserved byte 33h
	localparam logic       P32_FR_112     = 1'b1;
	localparam logic [1:0] P32_ADDR_BYTES = 2'b00;
	localparam logic       P32_DTR        = 1'b0;
	localparam logic       P32_FR_122     = 1'b1;
	localparam logic       P32_FR_144     = 1'b1;
	localparam logic       P32_FR_114     = 1'b1;
	localparam logic       P32_UNUSED     = 1'b1;
	localparam logic [7:0] P33_RESERVED   = 8'hff;

endpackage : flash_id_pkg

// ==== rtl/byte_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Honest full and empty straight from the occupancy count
	assign in_ready  = (count_reg != (AW + 1)'(DEPTH)) && !flush;
	assign out_valid = (count_reg != '0) && !flush;
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage has no reset; only the pointers and the count decide what is valid
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// ==== rtl/flash_id_readout.sv ====
// Identification and discovery-table readout behind the serial flash pins
`timescale 1ns/10ps
`default_nettype none
module flash_id_readout #(
	parameter logic [7:0]   CMD_ID_READ        = 8'h9f,
	parameter logic [7:0]   CMD_MULTI_ID_READ  = 8'haf,
	parameter logic [7:0]   CMD_DISCOVERY_READ = 8'h5a,
	parameter logic [7:0]   MANUFACTURER_CODE  = 8'hc5,   // Arbitrary value
	parameter logic [7:0]   MEMORY_TYPE_CODE   = 8'h3c,   // Arbitrary value
	parameter logic [7:0]   MEMORY_CAP_CODE    = 8'h47,   // Arbitrary value
	parameter logic         EXEC_IN_PLACE_NOT_REQUIRED = 1'b1,
	parameter logic         PIN_IS_RESET       = 1'b0,
	parameter logic [7:0]   EXT_ID_SECOND      = 8'h00,
	parameter logic [111:0] FACTORY_DATA       = 112'h0,
	parameter logic [7:0]   ERASE_4K_CODE      = 8'h21,   // Arbitrary value
	parameter int           FIFO_DEPTH         = 4
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   sclk,
	input  wire logic                   chip_select_n,
	input  wire logic             [3:0] data_lines_i,
	output logic                  [3:0] data_lines_o,
	output logic                  [3:0] data_lines_oe,
	input  wire flash_id_pkg::proto_t   protocol,
	input  wire logic                   erase_program_busy
);
	// Pin synchronisers; the first stage feeds only the second
	logic       sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
	logic       cs_s1_reg, cs_s2_reg;
	logic [3:0] dq_s1_reg, dq_s2_reg;
	logic       rise;
	logic       fall;

	flash_id_pkg::state_t  state_reg;
	flash_id_pkg::source_t src_reg;
	logic [7:0]  cmd_sh_reg;
	logic [7:0]  cmd_next;
	logic [23:0] addr_reg;
	logic [23:0] addr_next;
	logic [4:0]  bit_cnt_reg;
	logic [4:0]  bit_cnt_next;
	logic [4:0]  dummy_len;
	logic [2:0]  lanes;
	logic        start;
	logic [10:0] start_idx;
	flash_id_pkg::source_t start_src;

	logic [10:0] gen_idx_reg;
	logic        gen_run_reg;
	logic [7:0]  gen_byte;
	logic [7:0]  ext_first;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_pop;
	logic [7:0]  fifo_out_data;
	logic        flush;

	logic [2:0]  out_w_reg;
	logic        out_line1_reg;
	logic [7:0]  out_sh_reg;
	logic [3:0]  bits_left_reg;
	logic [7:0]  out_word;
	logic [3:0]  out_val;

	// Two flops on every pin; sclk gets a third for edge finding
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_s3_reg <= 1'b0;
			cs_s1_reg   <= 1'b1;
			cs_s2_reg   <= 1'b1;
			dq_s1_reg   <= 4'h0;
			dq_s2_reg   <= 4'h0;
		end
		else
		begin
			sclk_s1_reg <= sclk;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_s3_reg <= sclk_s2_reg;
			cs_s1_reg   <= chip_select_n;
			cs_s2_reg   <= cs_s1_reg;
			dq_s1_reg   <= data_lines_i;
			dq_s2_reg   <= dq_s1_reg;
		end
	end

	// Data and sclk share the same delay, so sampling stays aligned
	assign rise  = sclk_s2_reg && !sclk_s3_reg;
	assign fall  = !sclk_s2_reg && sclk_s3_reg;
	assign flush = cs_s2_reg;

	// Bits taken per rising edge follow the protocol
	always_comb
	begin
		case (protocol)
			flash_id_pkg::PROTO_QUAD:
			begin
				lanes     = 3'h4;
				dummy_len = flash_id_pkg::DUMMY_QUAD;
				cmd_next  = {cmd_sh_reg[3:0], dq_s2_reg};
				addr_next = {addr_reg[19:0], dq_s2_reg};
			end
			flash_id_pkg::PROTO_DUAL:
			begin
				lanes     = 3'h2;
				dummy_len = flash_id_pkg::DUMMY_EXT_DUAL;
				cmd_next  = {cmd_sh_reg[5:0], dq_s2_reg[1:0]};
				addr_next = {addr_reg[21:0], dq_s2_reg[1:0]};
			end
			default:
			begin
				lanes     = 3'h1;
				dummy_len = flash_id_pkg::DUMMY_EXT_DUAL;
				cmd_next  = {cmd_sh_reg[6:0], dq_s2_reg[0]};
				addr_next = {addr_reg[22:0], dq_s2_reg[0]};
			end
		endcase
		bit_cnt_next = bit_cnt_reg + {2'b00, lanes};
	end

	// Link sequence; every step from command to data or ignore happens on a sampled rising edge, deselect returns to idle at once
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg   <= flash_id_pkg::ST_IDLE;
			cmd_sh_reg  <= 8'h00;
			addr_reg    <= 24'h000000;
			bit_cnt_reg <= 5'h00;
		end
		else if (cs_s2_reg)
		begin
			state_reg   <= flash_id_pkg::ST_IDLE;
			bit_cnt_reg <= 5'h00;
		end
		else
		begin
			case (state_reg)
				flash_id_pkg::ST_IDLE:
				begin
					state_reg   <= flash_id_pkg::ST_CMD;
					bit_cnt_reg <= 5'h00;
				end
				flash_id_pkg::ST_CMD:
				begin
					if (rise)
					begin
						cmd_sh_reg  <= cmd_next;
						bit_cnt_reg <= bit_cnt_next;
						if (bit_cnt_next == flash_id_pkg::CMD_BITS)
						begin
							bit_cnt_reg <= 5'h00;
							// A busy array leaves the code undecoded
							if (erase_program_busy)
								state_reg <= flash_id_pkg::ST_IGNORE;
							else if (cmd_next == CMD_ID_READ && protocol == flash_id_pkg::PROTO_EXTENDED)
								state_reg <= flash_id_pkg::ST_DATA;
							else if (cmd_next == CMD_MULTI_ID_READ && protocol != flash_id_pkg::PROTO_EXTENDED)
								state_reg <= flash_id_pkg::ST_DATA;
							else if (cmd_next == CMD_DISCOVERY_READ)
								state_reg <= flash_id_pkg::ST_ADDR;
							else
								state_reg <= flash_id_pkg::ST_IGNORE;
						end
					end
				end
				flash_id_pkg::ST_ADDR:
				begin
					if (rise)
					begin
						addr_reg    <= addr_next;
						bit_cnt_reg <= bit_cnt_next;
						if (bit_cnt_next == flash_id_pkg::ADDR_BITS)
						begin
							bit_cnt_reg <= 5'h00;
							state_reg   <= flash_id_pkg::ST_DUMMY;
						end
					end
				end
				flash_id_pkg::ST_DUMMY:
				begin
					if (rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (bit_cnt_reg + 5'h01 == dummy_len)
							state_reg <= flash_id_pkg::ST_DATA;
					end
				end
				default:
				begin
					// Data and ignore phases hold until chip select rises
					state_reg <= state_reg;
				end
			endcase
		end
	end

	// Start pulse for the byte source, raised as data phase opens
	always_comb
	begin
		start     = 1'b0;
		start_idx = 11'h000;
		start_src = flash_id_pkg::SRC_ID_FULL;
		if (!cs_s2_reg && rise && !erase_program_busy)
		begin
			if (state_reg == flash_id_pkg::ST_CMD && bit_cnt_next == flash_id_pkg::CMD_BITS)
			begin
				if (cmd_next == CMD_ID_READ && protocol == flash_id_pkg::PROTO_EXTENDED)
					start = 1'b1;
				else if (cmd_next == CMD_MULTI_ID_READ && protocol != flash_id_pkg::PROTO_EXTENDED)
				begin
					start     = 1'b1;
					start_src = flash_id_pkg::SRC_ID_SHORT;
				end
			end
			else if (state_reg == flash_id_pkg::ST_DUMMY && bit_cnt_reg + 5'h01 == dummy_len)
			begin
				start     = 1'b1;
				start_src = flash_id_pkg::SRC_TABLE;
				start_idx = addr_reg[10:0];
			end
		end
	end

	// First extended ID byte built from the factory options
	always_comb
	begin
		ext_first = 8'h00;
		ext_first[flash_id_pkg::EXT_PROTECT_POS] = flash_id_pkg::EXT_PROTECT_STD;
		ext_first[flash_id_pkg::EXT_EXEC_POS]    = EXEC_IN_PLACE_NOT_REQUIRED;
		ext_first[flash_id_pkg::EXT_PIN_POS]  = PIN_IS_RESET;
		ext_first[flash_id_pkg::EXT_ADDR_POS] = flash_id_pkg::EXT_ADDR_BYTE;
		ext_first[1:0]                        = flash_id_pkg::EXT_ARCH_UNIF;
	end

	// Byte for the current source index
	always_comb
	begin
		gen_byte = flash_id_pkg::TABLE_FILL;
		if (src_reg == flash_id_pkg::SRC_TABLE)
		begin
			if (gen_idx_reg < 11'h010)
				gen_byte = flash_id_pkg::TABLE_HEADER[gen_idx_reg[3:0]];
			else if (gen_idx_reg == flash_id_pkg::TABLE_PARAM_BASE)
				gen_byte = {flash_id_pkg::P30_UNUSED, flash_id_pkg::P30_WE_SEL, flash_id_pkg::P30_WE_REQ,
					flash_id_pkg::P30_WR_GRAN, flash_id_pkg::P30_ERASE_SIZE};
			else if (gen_idx_reg == flash_id_pkg::TABLE_PARAM_BASE + 11'h001)
				gen_byte = ERASE_4K_CODE;
			else if (gen_idx_reg == flash_id_pkg::TABLE_PARAM_BASE + 11'h002)
				gen_byte = {flash_id_pkg::P32_UNUSED, flash_id_pkg::P32_FR_114, flash_id_pkg::P32_FR_144,
					flash_id_pkg::P32_FR_122, flash_id_pkg::P32_DTR, flash_id_pkg::P32_ADDR_BYTES,
					flash_id_pkg::P32_FR_112};
			else if (gen_idx_reg == flash_id_pkg::TABLE_PARAM_LAST)
				gen_byte = flash_id_pkg::P33_RESERVED;
			else
				gen_byte = flash_id_pkg::TABLE_FILL;
		end
		else if (gen_idx_reg == 11'h000)
			gen_byte = MANUFACTURER_CODE;
		else if (gen_idx_reg == 11'h001)
			gen_byte = MEMORY_TYPE_CODE;
		else if (gen_idx_reg == 11'h002)
			gen_byte = MEMORY_CAP_CODE;
		else if (gen_idx_reg == flash_id_pkg::ID_UID_BASE)
			gen_byte = flash_id_pkg::UID_LENGTH;
		else if (gen_idx_reg == flash_id_pkg::ID_UID_BASE + 11'h001)
			gen_byte = ext_first;
		else if (gen_idx_reg == flash_id_pkg::ID_UID_BASE + 11'h002)
			gen_byte = EXT_ID_SECOND;
		else
			gen_byte = FACTORY_DATA[8'(111 - 8 * (gen_idx_reg - flash_id_pkg::ID_FACTORY_BASE)) -: 8];
	end

	// Byte source; stalls on a full FIFO, so pace follows the link
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gen_idx_reg <= 11'h000;
			gen_run_reg <= 1'b0;
			src_reg     <= flash_id_pkg::SRC_ID_FULL;
		end
		else if (cs_s2_reg)
			gen_run_reg <= 1'b0;
		else if (start)
		begin
			gen_idx_reg <= start_idx;
			gen_run_reg <= 1'b1;
			src_reg     <= start_src;
		end
		else if (gen_run_reg && fifo_in_ready)
		begin
			// Table index is 11 bits wide and simply rolls over
			gen_idx_reg <= gen_idx_reg + 11'h001;
			if (src_reg == flash_id_pkg::SRC_ID_SHORT && gen_idx_reg == flash_id_pkg::ID_SHORT_LAST)
				gen_run_reg <= 1'b0;
			else if (src_reg == flash_id_pkg::SRC_ID_FULL && gen_idx_reg == flash_id_pkg::ID_FULL_LAST)
				gen_run_reg <= 1'b0;
		end
	end

	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (flush),
		.in_valid  (gen_run_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (gen_byte),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// A new byte is taken only at a byte boundary on a falling edge
	assign fifo_pop = fall && (state_reg == flash_id_pkg::ST_DATA) && !cs_s2_reg && (bits_left_reg == 4'h0);
	assign out_word = (bits_left_reg == 4'h0) ? fifo_out_data : out_sh_reg;

	// Lane placement of the top bits, MSB first
	always_comb
	begin
		out_val = 4'h0;
		case (out_w_reg)
			3'h4: out_val = out_word[7:4];
			3'h2: out_val = {2'b00, out_word[7:6]};
			default:
			begin
				if (out_line1_reg)
					out_val = {2'b00, out_word[7], 1'b0};
				else
					out_val = {3'b000, out_word[7]};
			end
		endcase
	end

	// Output width chosen once per command
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_w_reg     <= 3'h1;
			out_line1_reg <= 1'b0;
		end
		else if (start)
		begin
			if (start_src == flash_id_pkg::SRC_ID_FULL)
			begin
				out_w_reg     <= 3'h1;
				out_line1_reg <= 1'b0;
			end
			else if (start_src == flash_id_pkg::SRC_ID_SHORT)
			begin
				out_w_reg     <= 3'h2;
				out_line1_reg <= 1'b0;
			end
			else
			begin
				out_w_reg     <= lanes;
				out_line1_reg <= (protocol == flash_id_pkg::PROTO_EXTENDED);
			end
		end
	end

	// Output shifter on falling edges; stream end releases the lines
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_sh_reg    <= 8'h00;
			bits_left_reg <= 4'h0;
			data_lines_o  <= 4'h0;
			data_lines_oe <= 4'h0;
		end
		else if (cs_s2_reg || state_reg != flash_id_pkg::ST_DATA)
		begin
			bits_left_reg <= 4'h0;
			data_lines_oe <= 4'h0;
		end
		else if (fall)
		begin
			if (bits_left_reg == 4'h0 && !fifo_out_valid)
				data_lines_oe <= 4'h0;
			else
			begin
				data_lines_o  <= out_val;
				data_lines_oe <= (out_w_reg == 3'h4) ? 4'hf : (out_w_reg == 3'h2) ? 4'h3 :
					(out_line1_reg ? 4'h2 : 4'h1);
				out_sh_reg    <= out_word << out_w_reg;
				bits_left_reg <= ((bits_left_reg == 4'h0) ? flash_id_pkg::BYTE_BITS : bits_left_reg)
					- {1'b0, out_w_reg};
			end
		end
	end
endmodule : flash_id_readout
`default_nettype wire

// ==== tb/flash_id_readout_chk.sv ====
// Concurrent checks on the readout block's pins, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module flash_id_readout_chk (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 sclk,
	input wire logic                 chip_select_n,
	input wire logic           [3:0] data_lines_i,
	input wire logic           [3:0] data_lines_o,
	input wire logic           [3:0] data_lines_oe,
	input wire flash_id_pkg::proto_t protocol,
	input wire logic                 erase_program_busy
);
	logic       sclk_q;
	logic [3:0] fall_age;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Cycles since the raw link clock last fell; saturates so it never wraps
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_q   <= 1'b0;
			fall_age <= 4'hf;
		end
		else
		begin
			sclk_q <= sclk;
			if (sclk_q && !sclk)
				fall_age <= 4'h0;
			else if (fall_age != 4'hf)
				fall_age <= fall_age + 4'h1;
		end
	end

	reset_quiet_a: assert property ($fell(rst) |-> data_lines_oe == 4'h0 && data_lines_o == 4'h0)
		else $error("pins driven out of reset");
	deselect_release_a: assert property (chip_select_n [*6] |-> data_lines_oe == 4'h0)
		else $error("lines driven while deselected");
	ext_lines_a: assert property (protocol == flash_id_pkg::PROTO_EXTENDED |-> data_lines_oe inside {4'h0, 4'h1, 4'h2})
		else $error("wrong lines driven in extended protocol");
	dual_lines_a: assert property (protocol == flash_id_pkg::PROTO_DUAL |-> data_lines_oe inside {4'h0, 4'h3})
		else $error("wrong lines driven in dual protocol");
	quad_lines_a: assert property (protocol == flash_id_pkg::PROTO_QUAD |-> data_lines_oe inside {4'h0, 4'h3, 4'hf})
		else $error("wrong lines driven in quad protocol");
	change_after_fall_a: assert property (!$stable(data_lines_o) && $past(data_lines_oe) != 4'h0 |-> fall_age <= 4'h5)
		else $error("output moved away from a clock fall");
	start_after_fall_a: assert property ($rose(|data_lines_oe) |-> fall_age <= 4'h5)
		else $error("output started away from a clock fall");
	steady_high_a: assert property (sclk && $past(sclk) |-> $stable(data_lines_o))
		else $error("output moved while link clock high");
	busy_silent_a: assert property ($rose(|data_lines_oe) |-> !$past(erase_program_busy, 8))
		else $error("answered a command while busy");

	id_line_c: cover property (data_lines_oe == 4'h1);
	table_ext_c: cover property (data_lines_oe == 4'h2);
	quad_out_c: cover property (data_lines_oe == 4'hf);
endmodule : flash_id_readout_chk

bind flash_id_readout flash_id_readout_chk chk (.clk(clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n),
	.data_lines_i(data_lines_i), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
	.protocol(protocol), .erase_program_busy(erase_program_busy));
`default_nettype wire

// ==== tb/flash_host_model.sv ====
// Host serial controller model: selects the device, clocks and shifts the link
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
	input  wire logic       clk,
	output logic            sclk,
	output logic            chip_select_n,
	output logic      [3:0] data_lines_i,
	input  wire logic [3:0] data_lines_o,
	input  wire logic [3:0] data_lines_oe
);
	logic [3:0] drv_val;
	logic [3:0] drv_en;
	logic [3:0] junk;
	logic [7:0] rx_byte;
	int         phase;
	event       rx_ev;

	initial
	begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		drv_en = 4'h0;
		drv_val = 4'h0;
		junk = 4'h5;
		phase = 0;
	end

	// Undriven lines toggle so a stale value can never pass for data
	always @(negedge clk)
		junk <= ~junk;

	// Wire level from the host's and the device's enables
	always_comb
		for (int i = 0; i < 4; i++)
			data_lines_i[i] = drv_en[i] ? drv_val[i] : data_lines_oe[i] ? data_lines_o[i] : junk[i];

	// Select with setup before the first clock, or deselect and rest
	task automatic select(input logic on);
		@(negedge clk);
		chip_select_n = !on;
		drv_en = 4'h0;
		repeat (on ? 6 : 10) @(negedge clk);
	endtask : select

	// Lines change in the low phase, both sides sample at the rise, MSB first
	task automatic shift(input logic [31:0] val, input int steps, input int w, input int lo, input logic drive,
		output logic [31:0] got);
		logic [3:0] m;
		m = w == 4 ? 4'hf : w == 2 ? 4'h3 : 4'h1;
		got = '0;
		val = val << (32 - steps * w);
		for (int s = 0; s < steps; s++)
		begin
			drv_en = drive ? m << lo : 4'h0;
			drv_val = 4'(val >> (32 - w)) << lo;
			val = val << w;
			repeat (6 + phase) @(negedge clk);
			phase = 1 - phase;  // 12 and 13 cycles alternate for a 125 ns mean period
			sclk = 1'b1;
			got = (got << w) | 32'((data_lines_i >> lo) & m);
			repeat (6) @(negedge clk);
			sclk = 1'b0;
		end
	endtask : shift

	// Capture one whole byte and hand it to the watcher
	task automatic read_byte(input int w, input int lo);
		logic [31:0] got;
		shift(32'h0, 8 / w, w, lo, 1'b0, got);
		rx_byte = got[7:0];
		-> rx_ev;
	endtask : read_byte
endmodule : flash_host_model
`default_nettype wire

// ==== tb/flash_id_readout_tb.sv ====
// Self-checking bench for the identification and discovery-table readout
`timescale 1ns/10ps
`default_nettype none
module flash_id_readout_tb;
	localparam logic [7:0] ID_C = 8'h9f;
	localparam logic [7:0] MID_C = 8'haf;
	localparam logic [7:0] TBL_C = 8'h5a;
	localparam logic [7:0] MFR = 8'hc5;    // Arbitrary value
	localparam logic [7:0] TYP = 8'h3c;    // Arbitrary value
	localparam logic [7:0] CAP = 8'h47;    // Arbitrary value
	localparam logic [7:0] ERASE = 8'h21;  // Arbitrary value
	localparam logic [7:0] EXT2 = 8'h5c;   // Second extended ID byte, arbitrary
	localparam logic [111:0] FAC = 112'h0123456789abcdeffedcba987654;  // First factory byte in 111:104
	localparam logic [7:0] HDR [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};

	logic                 clk;
	logic                 rst;
	logic                 busy;
	flash_id_pkg::proto_t protocol;
	wire logic            sclk;
	wire logic            chip_select_n;
	wire logic      [3:0] data_lines_i;
	wire logic      [3:0] data_lines_o;
	wire logic      [3:0] data_lines_oe;
	logic           [7:0] exp_q [$];
	logic           [7:0] msk_q [$];
	logic          [31:0] lfsr;
	int                   err_total;
	int                   checks;

	// Codes stay at their defaults; PIN_IS_RESET, EXT_ID_SECOND and FACTORY_DATA are moved off theirs so the bytes are seen
	flash_id_readout #(.PIN_IS_RESET(1'b1), .EXT_ID_SECOND(EXT2), .FACTORY_DATA(FAC))
	uut (.clk(clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n), .data_lines_i(data_lines_i),
		.data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .protocol(protocol),
		.erase_program_busy(busy));

	flash_host_model host (.clk(clk), .sclk(sclk), .chip_select_n(chip_select_n), .data_lines_i(data_lines_i),
		.data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));

	always #5 clk = ~clk;

	function automatic logic [7:0] tbl(input logic [10:0] a);
		if (a < 11'h010)
			return HDR[a[3:0]];
		case (a)
			11'h030: return 8'he5;
			11'h031: return ERASE;
			11'h032: return 8'hf1;
			default: return 8'hff;
		endcase
	endfunction : tbl

	function automatic logic [31:0] lfsr_step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_step

	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen, input logic [7:0] m);
		checks++;
		if ((seen & m) !== (exp & m))
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp

	task automatic note(input logic [7:0] v, input logic [7:0] m);
		exp_q.push_back(v);
		msk_q.push_back(m);
	endtask : note

	// Each captured byte is judged against the oldest note
	always @(host.rx_ev)
	begin
		if (exp_q.size() == 0)
			cmp("unexpected byte", 8'h00, 8'hff, 8'hff);
		else
			cmp("byte", exp_q.pop_front(), host.rx_byte, msk_q.pop_front());
	end

	task automatic cmd(input logic [7:0] code, input int w);
		logic [31:0] got;
		host.select(1'b1);
		host.shift(32'(code), 8 / w, w, 0, 1'b1, got);
	endtask : cmd

	// Deselect; the device must have let go of every line by then
	task automatic end_frame;
		host.select(1'b0);
		cmp("oe after deselect", 8'h00, {4'h0, data_lines_oe}, 8'hff);
	endtask : end_frame

	// A refused or finished answer leaves every line undriven
	task automatic silent;
		logic [31:0] got;
		host.shift(32'h0, 8, 1, 0, 1'b0, got);
		cmp("oe while silent", 8'h00, {4'h0, data_lines_oe}, 8'hff);
		end_frame();
	endtask : silent

	task automatic table_read(input logic [23:0] addr, input int w, input int n);
		logic [31:0] got;
		cmd(TBL_C, w);
		host.shift(32'(addr), 24 / w, w, 0, 1'b1, got);
		host.shift(32'h0, protocol == flash_id_pkg::PROTO_QUAD ? 10 : 8, 1, 0, 1'b0, got);
		for (int i = 0; i < n; i++)
		begin
			note(tbl(addr[10:0] + 11'(i)), 8'hff);
			host.read_byte(w, w == 1 ? 1 : 0);
		end
		end_frame();
	endtask : table_read

	task automatic close_out;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// Watchdog so a stalled run still reaches the verdict
	initial
	begin
		repeat (90000) @(posedge clk);
		err_total++;
		close_out();
	end

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		busy = 1'b0;
		protocol = flash_id_pkg::PROTO_EXTENDED;
		lfsr = 32'h419e;
		err_total = 0;
		checks = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		// Full single-line identification, then the line is released
		cmd(ID_C, 1);
		note(MFR, 8'hff);
		note(TYP, 8'hff);
		note(CAP, 8'hff);
		note(8'h10, 8'hff);
		note(8'h18, 8'h3f);
		note(EXT2, 8'hff);
		for (int i = 0; i < 14; i++)
			note(FAC[111 - 8 * i -: 8], 8'hff);
		repeat (20) host.read_byte(1, 0);
		silent();
		// Refusals: busy array, multi-line code in extended, single-line code in dual
		busy = 1'b1;
		cmd(ID_C, 1);
		silent();
		busy = 1'b0;
		cmd(MID_C, 1);
		silent();
		protocol = flash_id_pkg::PROTO_DUAL;
		cmd(ID_C, 2);
		silent();
		// Multi-line identification stops before the unique identifier
		for (int p = 0; p < 2; p++)
		begin
			protocol = p == 0 ? flash_id_pkg::PROTO_DUAL : flash_id_pkg::PROTO_QUAD;
			cmd(MID_C, p == 0 ? 2 : 4);
			note(MFR, 8'hff);
			note(TYP, 8'hff);
			note(CAP, 8'hff);
			repeat (3) host.read_byte(2, 0);
			silent();
		end
		// Reset in mid-run between frames; the lines must stay released
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		cmp("oe after reset", 8'h00, {4'h0, data_lines_oe}, 8'hff);
		// Aborted after the first byte
		cmd(MID_C, 4);
		note(MFR, 8'hff);
		host.read_byte(2, 0);
		end_frame();
		// Extended table read across the wrap, covering the whole table
		protocol = flash_id_pkg::PROTO_EXTENDED;
		table_read(24'h0007fe, 1, 54);
		// Dual and quad reads from random addresses, ended mid-output
		for (int p = 0; p < 2; p++)
		begin
			lfsr = lfsr_step(lfsr);
			protocol = p == 0 ? flash_id_pkg::PROTO_DUAL : flash_id_pkg::PROTO_QUAD;
			table_read({lfsr[23:11], 11'(lfsr[5:0] % 52)}, p == 0 ? 2 : 4, 6);
		end
		close_out();
	end
endmodule : flash_id_readout_tb
`default_nettype wire
